/* File: pmc_pkg.sv */
// Package for the power mode controller: register map, field positions, resets, modes.
// Assumes a 32-bit AXI4-Lite register bus and a single 50 MHz clock.
package pmc_pkg;
  // ==========================================
  // Register offsets (byte addresses)
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] WAKEEN_OFS = 8'h04;
  localparam logic [7:0] GATE_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS   = 8'h0c;
  localparam logic [7:0] IRQST_OFS  = 8'h10;
  localparam logic [7:0] IRQMSK_OFS = 8'h14;
  localparam logic [7:0] PMRST_OFS  = 8'h18;
  // ==========================================
  // Control register fields
  localparam int CTRL_DEEP_BIT   = 0;
  localparam int CTRL_POWER_MODE_SELECT_BIT_BIT  = 1;
  localparam int CTRL_RAMX_BIT   = 2;
  localparam int CTRL_FAST_BIT   = 3;
  localparam int CTRL_LFSEL_BIT  = 4;
  // Wake source bit positions
  localparam int W_RTC_ALARM   = 0;
  localparam int W_RTC_FAIL    = 1;
  localparam int W_LPTIMER     = 2;
  localparam int W_SUPPLY_LOW  = 3;
  localparam int W_REG_LOW     = 4;
  localparam int W_CMP0        = 5;
  localparam int W_PIN_WAKE    = 6;
  localparam int W_PORT_MATCH  = 7;
  localparam int W_EXT_A       = 8;
  localparam int W_EXT_B       = 9;
  localparam int WAKE_W        = 10;
  // Interrupt status bits
  localparam int IRQ_WAKE_BIT  = 0;
  localparam int IRQ_ENTER_BIT = 1;
  localparam int IRQ_W         = 2;
  // Reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] WAKEEN_RST = 32'h0000_0000;
  localparam logic [31:0] GATE_RST   = 32'hffff_ffff;
  localparam logic [31:0] PMRST_RST  = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  // Power modes as reported in status
  typedef enum logic [3:0] {
    PM0 = 4'h0, PM1 = 4'h1, PM2 = 4'h2, PM3 = 4'h3, PM9 = 4'h9
  } pmode_t;
endpackage

/* File: power_mode_controller.sv */
// Power mode controller: sequences run, sleep, deep sleep and the reset-only lowest state.
// Assumes sleep requests from the core, wake and reset sources as asynchronous pins.
// Behaviour
// - After reset run in mode 0, everything clocked, fetching from flash.
// - Mode 1 keeps core and peripherals running, fetching from RAM without waits.
// - Mode 2 halts the core; enabled peripherals and bus clocks keep running.
// - In mode 2 peripheral-bus interrupts, including port events, wake the core.
// - Mode 3 halts both system bus clock and peripheral bus clock.
// - Mode 3 wakes only on enabled clock-free sources: RTC, timer, supply, regulator, comparator, pin wake.
// - With fast wake, mode 3 runs on slow clock, switches to fast oscillator on wake.
// - Entering mode 3 halts the fast oscillator into suspended low-power state.
// - Wait-for-interrupt or wait-for-event enters mode 2, 3 or 9 per configuration.
// - Mode 9 halts core, peripherals and all clocks; pins go low-power.
// - Mode 9 loses standard RAM; retention RAM stays valid.
// - Mode 9 is left only by a previously enabled reset source.
// - Each peripheral clock is individually gated by the clock gate control.
// - Timer, RTC alarm and failure, comparator and pin wake are wake sources.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
module power_mode_controller
  import pmc_pkg::*;
#(
  parameter int NPERIPH = 32,
  parameter int NRST    = 8
)(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                wfi_req,
  input  wire logic                wfe_req,
  input  wire logic                periph_irq,
  input  wire logic [WAKE_W-1:0]   wake_in,
  input  wire logic [NRST-1:0]     reset_src_in,
  output logic                     core_clk_en,
  output logic                     ahb_clk_en,
  output logic                     apb_clk_en,
  output logic [NPERIPH-1:0]       periph_clk_en,
  output logic                     fetch_from_ram,
  output logic                     fast_low_power_oscillator_en,
  output logic                     fast_low_power_oscillator_suspend,
  output logic                     low_freq_oscillator_sel,
  output logic                     rtc_timer_clock_sel,
  output logic                     pins_low_power,
  output logic                     std_ram_power,
  output logic                     retention_ram_power,
  output logic                     wake_reset_req,
  output logic [3:0]               power_mode,
  output logic                     irq
);
  // ==========================================
  // Input synchronisers
  logic [WAKE_W-1:0] wake_s1_r, wake_s2_r;
  logic [NRST-1:0]   rst_s1_r, rst_s2_r;
  logic [2:0]        cpu_s1_r, cpu_s2_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_s1_r <= '0;
      wake_s2_r <= '0;
      rst_s1_r  <= '0;
      rst_s2_r  <= '0;
      cpu_s1_r  <= '0;
      cpu_s2_r  <= '0;
    end else begin
      wake_s1_r <= wake_in;
      wake_s2_r <= wake_s1_r;
      rst_s1_r  <= reset_src_in;
      rst_s2_r  <= rst_s1_r;
      cpu_s1_r  <= {periph_irq, wfe_req, wfi_req};
      cpu_s2_r  <= cpu_s1_r;
    end
  end

  // ==========================================
  // Registers
  logic [31:0]        ctrl_r, wakeen_r, gate_r, pmrst_r;
  logic [IRQ_W-1:0]   irqst_r, irqmsk_r;
  pmode_t             mode_r, mode_nxt;
  logic               deep_sleep_request, power_mode_select_bit;

  assign deep_sleep_request    = ctrl_r[CTRL_DEEP_BIT];
  assign power_mode_select_bit = pmrst_r[0];

  // Run modes keep the core clocked
  function automatic logic is_run(input pmode_t m);
    return (m == PM0) || (m == PM1);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // ==========================================
  // AXI4-Lite write channel; address and data taken in either order
  logic        aw_held_r, w_held_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == STAT_OFS || awaddr_r > PMRST_OFS || awaddr_r[1:0] != 2'b00)
                      ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-written registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r   <= CTRL_RST;
      wakeen_r <= WAKEEN_RST;
      gate_r   <= GATE_RST;
      pmrst_r  <= PMRST_RST;
      irqmsk_r <= '0;
    end else if (do_write) begin
      case (awaddr_r)
        CTRL_OFS:   ctrl_r   <= merge(ctrl_r, wdata_r, wstrb_r);
        WAKEEN_OFS: wakeen_r <= merge(wakeen_r, wdata_r, wstrb_r);
        GATE_OFS:   gate_r   <= merge(gate_r, wdata_r, wstrb_r);
        PMRST_OFS:  pmrst_r  <= merge(pmrst_r, wdata_r, wstrb_r);
        IRQMSK_OFS: if (wstrb_r[0]) irqmsk_r <= wdata_r[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  logic        rd_take;
  logic [31:0] rd_val;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      CTRL_OFS:   rd_val = ctrl_r;
      WAKEEN_OFS: rd_val = wakeen_r;
      GATE_OFS:   rd_val = gate_r;
      STAT_OFS:   rd_val = {28'h0000000, mode_r};
      IRQST_OFS:  rd_val = {{(32-IRQ_W){1'b0}}, irqst_r};
      IRQMSK_OFS: rd_val = {{(32-IRQ_W){1'b0}}, irqmsk_r};
      PMRST_OFS:  rd_val = pmrst_r;
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= (s_axi_araddr > PMRST_OFS || s_axi_araddr[1:0] != 2'b00)
                      ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // Mode sequencer
  logic [WAKE_W-1:0] wake_lvl;
  logic sleep_cmd, wake_pm2, wake_pm3, reset_pm9;
  logic [WAKE_W-1:0] pm3_mask;

  assign wake_lvl  = wake_s2_r & wakeen_r[WAKE_W-1:0];
  assign sleep_cmd = cpu_s2_r[0] | cpu_s2_r[1];
  // Sources whose logic needs no peripheral bus clock
  assign pm3_mask  = WAKE_W'((1 << W_RTC_ALARM) | (1 << W_RTC_FAIL) | (1 << W_LPTIMER)
                     | (1 << W_SUPPLY_LOW) | (1 << W_REG_LOW) | (1 << W_CMP0)
                     | (1 << W_PIN_WAKE));
  // Any peripheral interrupt or enabled wake source, port events included
  assign wake_pm2  = cpu_s2_r[2] | (|wake_lvl);
  assign wake_pm3  = |(wake_lvl & pm3_mask);
  // Only reset sources armed in the power manager count
  assign reset_pm9 = |(rst_s2_r & pmrst_r[8 +: NRST]);

  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      PM0, PM1: begin
        if (sleep_cmd) begin
          if (!deep_sleep_request) mode_nxt = PM2;
          else if (power_mode_select_bit) mode_nxt = PM9;
          else mode_nxt = PM3;
        end else begin
          mode_nxt = ctrl_r[CTRL_RAMX_BIT] ? PM1 : PM0;
        end
      end
      PM2: if (wake_pm2) mode_nxt = ctrl_r[CTRL_RAMX_BIT] ? PM1 : PM0;
      PM3: if (wake_pm3) mode_nxt = ctrl_r[CTRL_RAMX_BIT] ? PM1 : PM0;
      // No wake path other than an armed reset
      PM9: if (reset_pm9) mode_nxt = PM0;
      default: mode_nxt = PM0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) mode_r <= PM0;
    else mode_r <= mode_nxt;
  end

  // Armed reset leaves PM9 and asks for a device reset
  always_ff @(posedge aclk) begin
    if (!aresetn) wake_reset_req <= 1'b0;
    else wake_reset_req <= (mode_r == PM9) && reset_pm9;
  end

  // ==========================================
  // Clock, oscillator and power outputs
  logic running, in3, in9;
  assign running = is_run(mode_r);
  assign in3     = (mode_r == PM3);
  assign in9     = (mode_r == PM9);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_clk_en    <= 1'b1;
      ahb_clk_en     <= 1'b1;
      apb_clk_en     <= 1'b1;
      periph_clk_en  <= '1;
      fetch_from_ram <= 1'b0;
      pins_low_power <= 1'b0;
      std_ram_power  <= 1'b1;
      power_mode     <= 4'h0;
    end else begin
      core_clk_en    <= running;
      ahb_clk_en     <= !in3 && !in9;
      apb_clk_en     <= !in3 && !in9;
      // Gating applies in modes 0, 1 and 2; deep modes 3 and 9 force all off
      periph_clk_en  <= (in3 || in9) ? '0 : gate_r[NPERIPH-1:0];
      fetch_from_ram <= (mode_r == PM1);
      pins_low_power <= in9;
      std_ram_power  <= !in9;
      power_mode     <= mode_r;
    end
  end
  assign retention_ram_power = 1'b1;

  // Fast wake: park on slow clock while in mode 3, fast oscillator resumes on wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fast_low_power_oscillator_en      <= 1'b1;
      fast_low_power_oscillator_suspend <= 1'b0;
      low_freq_oscillator_sel           <= 1'b0;
      rtc_timer_clock_sel               <= 1'b0;
    end else begin
      fast_low_power_oscillator_en      <= !(in3 || in9);
      fast_low_power_oscillator_suspend <= in3;
      low_freq_oscillator_sel           <= in3 && ctrl_r[CTRL_FAST_BIT]
                                           && ctrl_r[CTRL_LFSEL_BIT];
      rtc_timer_clock_sel               <= in3 && ctrl_r[CTRL_FAST_BIT]
                                           && !ctrl_r[CTRL_LFSEL_BIT];
    end
  end

  // ==========================================
  // Interrupts: set on wake from mode 2 or 3 and on sleep entry; set wins over read clear
  logic [IRQ_W-1:0] irq_set;
  logic             irqst_rd;
  // Next mode is passed as an argument so the set terms follow every change of it
  always_comb begin
    irq_set                = '0;
    irq_set[IRQ_WAKE_BIT]  = (mode_r == PM2 || in3) && is_run(mode_nxt);
    irq_set[IRQ_ENTER_BIT] = running && !is_run(mode_nxt);
  end
  assign irqst_rd = rd_take && (s_axi_araddr == IRQST_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) irqst_r <= '0;
    else irqst_r <= (irqst_rd ? '0 : irqst_r) | irq_set;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(irqst_r & irqmsk_r);
  end
endmodule

/* File: power_mode_controller_props.sv */
// Checker for the power mode controller: mode entry, wake and clock gating at the ports.
// Assumes it is bound to the top module; one clock, synchronous active-low reset.
module power_mode_controller_props
  import pmc_pkg::*;
#(
  parameter int NRST = 8
)(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              wfi_req,
  input wire logic              wfe_req,
  input wire logic              periph_irq,
  input wire logic [WAKE_W-1:0] wake_in,
  input wire logic [NRST-1:0]   reset_src_in,
  input wire logic              core_clk_en,
  input wire logic              ahb_clk_en,
  input wire logic              apb_clk_en,
  input wire logic              fast_low_power_oscillator_en,
  input wire logic              fast_low_power_oscillator_suspend,
  input wire logic              pins_low_power,
  input wire logic              std_ram_power,
  input wire logic              retention_ram_power,
  input wire logic              wake_reset_req,
  input wire logic [3:0]        power_mode
);
  // ==========================================
  // Helpers
  logic sleep_any;
  assign sleep_any = wfi_req | wfe_req;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Four quiet samples cover the two-stage synchroniser and the mode register
  sequence s_pm3_quiet;
    (power_mode == PM3 && wake_in[6:0] == 7'h00) [*4];
  endsequence
  sequence s_pm9_quiet;
    (power_mode == PM9 && reset_src_in == '0) [*4];
  endsequence
  sequence s_pm2_irq;
    (power_mode == PM2 && periph_irq) [*3];
  endsequence
  // ==========================================
  // Properties
  AST_PM2_CORE_HALT: assert property (power_mode == PM2 |-> !core_clk_en)
    else $error("core clock runs in mode 2");
  AST_PM2_IRQ_WAKE: assert property (s_pm2_irq |-> ##[1:2] power_mode != PM2)
    else $error("peripheral interrupt did not wake mode 2");
  AST_PM3_BUS_HALT: assert property (power_mode == PM3 |-> !ahb_clk_en && !apb_clk_en)
    else $error("bus clock runs in mode 3");
  AST_PM3_NO_WAKE: assert property (s_pm3_quiet |=> power_mode == PM3)
    else $error("mode 3 left without a clock-free wake source");
  AST_PM3_OSC_SUSPEND: assert property (power_mode == PM3 |->
    fast_low_power_oscillator_suspend && !fast_low_power_oscillator_en)
    else $error("fast oscillator not suspended in mode 3");
  AST_ENTER_CAUSE: assert property (
    power_mode inside {PM2, PM3, PM9} && power_mode != $past(power_mode) |->
    $past(sleep_any, 2) || $past(sleep_any, 3) || $past(sleep_any, 4))
    else $error("sleep entered without a sleep instruction");
  AST_PM9_ALL_STOP: assert property (power_mode == PM9 |->
    !core_clk_en && !ahb_clk_en && !apb_clk_en && pins_low_power && !std_ram_power)
    else $error("clocks or pins active in mode 9");
  AST_RETENTION: assert property (retention_ram_power)
    else $error("retention memory unpowered");
  AST_PM9_HOLD: assert property (s_pm9_quiet |=> power_mode == PM9)
    else $error("mode 9 left without a reset source");
  AST_PM9_EXIT: assert property ($past(power_mode) == PM9 && power_mode != PM9 |->
    power_mode == PM0)
    else $error("mode 9 left to a mode other than 0");
  AST_WAKE_PULSE: assert property (wake_reset_req |=> !wake_reset_req)
    else $error("wake reset request longer than one cycle");
endmodule

/* File: core_sleep_model.sv */
// Model of the processor core issuing wait-for-interrupt or wait-for-event.
// Assumes go is a one-cycle strobe and use_wfe is held steady around it.
module core_sleep_model #(
  parameter int DRAIN = 3
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic go,
  input  wire logic use_wfe,
  output logic      wfi_req,
  output logic      wfe_req
);
  int cnt;
  // Barriers drain pending accesses first; request held 3 cycles to cross the synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt     <= 0;
      wfi_req <= 1'b0;
      wfe_req <= 1'b0;
    end else begin
      if (go) cnt <= DRAIN + 3;
      else if (cnt != 0) cnt <= cnt - 1;
      wfi_req <= (cnt inside {[1:3]}) && !use_wfe;
      wfe_req <= (cnt inside {[1:3]}) && use_wfe;
    end
  end
endmodule

/* File: power_mode_controller_test.sv */
// Self-checking bench for the power mode controller.
// Assumes the core model drives the sleep requests; the bench is the bus master.
module power_mode_controller_test
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, go = 0, use_wfe = 0, periph_irq = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, periph_clk_en;
  logic [3:0] s_axi_wstrb = 4'hf, power_mode;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [9:0] wake_in = 0;
  logic [7:0] reset_src_in = 0;
  logic wfi_req, wfe_req, core_clk_en, ahb_clk_en, apb_clk_en, fetch_from_ram, irq;
  logic fast_low_power_oscillator_en, fast_low_power_oscillator_suspend, low_freq_oscillator_sel;
  logic rtc_timer_clock_sel, pins_low_power, std_ram_power, retention_ram_power, wake_reset_req;
  int bad_count = 0, checks_done = 0, cycles = 0;
  typedef struct packed {logic [7:0] ctrl; logic wfe; logic [3:0] m; logic pi; logic [9:0] wk;} row_t;
  row_t rows [7] = '{'{8'h00, 1'b0, 4'h2, 1'b1, 10'h000}, '{8'h00, 1'b1, 4'h2, 1'b0, 10'h080},
    '{8'h01, 1'b0, 4'h3, 1'b0, 10'h001}, '{8'h01, 1'b1, 4'h3, 1'b0, 10'h004},
    '{8'h19, 1'b0, 4'h3, 1'b0, 10'h010}, '{8'h09, 1'b1, 4'h3, 1'b0, 10'h008},
    '{8'h01, 1'b0, 4'h3, 1'b0, 10'h002}};
  power_mode_controller power_mode_controller_i (.*);
  core_sleep_model core_sleep_model_i (.aclk, .aresetn, .go, .use_wfe, .wfi_req, .wfe_req);
  always #10 aclk = ~aclk;
  // ==========================================
  // Tasks
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    cmp_val({30'h0, g}, {30'h0, e});
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask
  task automatic wait_mode(input logic [3:0] m);
    for (int n = 0; n < 40 && power_mode !== m; n++) @(posedge aclk);
  endtask
  task automatic sleep(input logic w);
    go <= 1; use_wfe <= w;
    @(posedge aclk);
    go <= 0;
  endtask
  // ==========================================
  // Sequence
  initial begin
    logic [31:0] d;
    logic [1:0] rs;
    logic seen;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cmp_val(power_mode, PM0);
    cmp_val({core_clk_en, ahb_clk_en, apb_clk_en, fetch_from_ram, std_ram_power}, 5'h1d);
    cmp_val(periph_clk_en, 32'hffff_ffff);
    axi_rd(GATE_OFS, d, rs); cmp_val(d, GATE_RST);
    axi_wr(WAKEEN_OFS, 32'h0000_03ff, rs); cmp_resp(rs, RESP_OKAY);
    axi_wr(IRQMSK_OFS, 32'h0000_0003, rs);
    foreach (rows[i]) begin
      axi_wr(CTRL_OFS, {24'h0, rows[i].ctrl}, rs);
      sleep(rows[i].wfe);
      wait_mode(rows[i].m); cmp_val(power_mode, rows[i].m);
      repeat (2) @(posedge aclk);
      if (rows[i].m == PM2) cmp_val({core_clk_en, ahb_clk_en, apb_clk_en}, 3'b011);
      else begin
        cmp_val({ahb_clk_en, apb_clk_en, fast_low_power_oscillator_suspend}, 3'b001);
        if (rows[i].ctrl[3]) cmp_val(low_freq_oscillator_sel, rows[i].ctrl[4]);
        cmp_val(rtc_timer_clock_sel, rows[i].ctrl[3] && !rows[i].ctrl[4]);
        periph_irq <= 1; wake_in <= 10'h380;
        repeat (6) @(posedge aclk);
        cmp_val(power_mode, PM3);
      end
      periph_irq <= rows[i].pi; wake_in <= rows[i].wk;
      wait_mode(PM0); cmp_val(power_mode, PM0);
      periph_irq <= 0; wake_in <= 0;
      repeat (2) @(posedge aclk);
      cmp_val({core_clk_en, fast_low_power_oscillator_en}, 2'b11);
    end
    cmp_val(irq, 1);
    axi_wr(IRQMSK_OFS, 32'h0, rs); repeat (2) @(posedge aclk); cmp_val(irq, 0);
    axi_wr(IRQMSK_OFS, 32'h3, rs); repeat (2) @(posedge aclk); cmp_val(irq, 1);
    axi_rd(IRQST_OFS, d, rs); cmp_val(d[1:0], 2'b11);
    repeat (2) @(posedge aclk); cmp_val(irq, 0);
    axi_wr(CTRL_OFS, 32'h4, rs); wait_mode(PM1); @(posedge aclk);
    cmp_val({power_mode, fetch_from_ram, core_clk_en}, {PM1, 2'b11});
    axi_wr(CTRL_OFS, 32'h0, rs); wait_mode(PM0);
    axi_wr(GATE_OFS, 32'h0000_00a5, rs); repeat (2) @(posedge aclk);
    cmp_val(periph_clk_en, 32'h0000_00a5);
    axi_wr(STAT_OFS, 32'h1, rs); cmp_resp(rs, RESP_SLVERR);
    axi_rd(8'h40, d, rs); cmp_resp(rs, RESP_SLVERR);
    axi_rd(STAT_OFS, d, rs); cmp_val(d[3:0], PM0);
    axi_wr(PMRST_OFS, 32'h0000_0201, rs); axi_wr(CTRL_OFS, 32'h1, rs);
    sleep(1'b0);
    wait_mode(PM9); cmp_val(power_mode, PM9);
    repeat (2) @(posedge aclk);
    cmp_val({core_clk_en, ahb_clk_en, apb_clk_en, pins_low_power, std_ram_power}, 5'h02);
    cmp_val(retention_ram_power, 1);
    reset_src_in <= 8'h01; repeat (8) @(posedge aclk); cmp_val(power_mode, PM9);
    reset_src_in <= 8'h02; seen = 0;
    repeat (8) begin
      @(posedge aclk);
      if (wake_reset_req === 1'b1) seen = 1;
    end
    cmp_val({seen, power_mode}, {1'b1, PM0});
    reset_src_in <= 0;
    // Mid-run reset: gating, mode, interrupt and reset config return to defaults
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cmp_val(periph_clk_en, 32'hffff_ffff);
    cmp_val({power_mode, irq}, {PM0, 1'b0});
    axi_rd(PMRST_OFS, d, rs); cmp_val(d, PMRST_RST);
    report_and_stop();
  end
  // Hang guard: the sequence needs well under 2000 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
endmodule
bind power_mode_controller power_mode_controller_props #(.NRST(NRST)) power_mode_controller_props_i (.*);
